/* cbcc_pkg.sv */
package cbcc_pkg;

    typedef enum logic [2:0] {
        CYC_INT_ACK,
        CYC_IO_READ,
        CYC_IO_WRITE,
        CYC_MEM_READ,
        CYC_MEM_WRITE,
        CYC_HALT,
        CYC_NONE
    } cbcc_cycle_t;

    typedef enum logic [1:0] {
        FAM_READ,
        FAM_WRITE,
        FAM_HALT,
        FAM_NONE
    } cbcc_family_t;

    typedef struct packed {
        logic mem_io_select;
        logic status1_n;
        logic status0_n;
    } cbcc_status_t;

    typedef struct packed {
        logic int_ack_strobe_n;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
        logic mem_read_strobe_n;
        logic mem_write_strobe_n;
    } cbcc_cmd_t;

    localparam logic [2:0] CODE_INT_ACK = 3'h0;
    localparam logic [2:0] CODE_IO_READ = 3'h1;
    localparam logic [2:0] CODE_IO_WRITE = 3'h2;
    localparam logic [2:0] CODE_HALT = 3'h4;
    localparam logic [2:0] CODE_MEM_READ = 3'h5;
    localparam logic [2:0] CODE_MEM_WRITE = 3'h6;

    // Command-state cycles before a strobe may go active
    localparam logic [1:0] READ_DELAY_FAST = 2'h0;
    localparam logic [1:0] READ_DELAY_SHARED = 2'h1;
    localparam logic [1:0] WRITE_DELAY_FAST = 2'h0;
    localparam logic [1:0] WRITE_DELAY_SHARED = 2'h2;
    localparam logic [1:0] CMD_INDEX_MAX = 2'h3;

    localparam cbcc_cmd_t CMD_ALL_INACTIVE = 5'h1F;
    localparam logic SYNC_RESET_VALUE = 1'b0;
    localparam logic DIR_RESET_VALUE = 1'b1;
    localparam logic OE_RESET_VALUE = 1'b1;

endpackage : cbcc_pkg

/* cbcc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module cbcc_sync
    import cbcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level crossing
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;
    logic sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= SYNC_RESET_VALUE;
            sync_q <= SYNC_RESET_VALUE;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : cbcc_sync
`default_nettype wire

/* cbcc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cbcc_top
    import cbcc_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Processor status
    input wire cbcc_status_t BUS_STATUS,
    input wire logic READY_N,
    // Control inputs
    input wire logic SHARED_BUS_TIMING_STRAP,
    input wire logic COMMAND_ENABLE_OR_GRANT,
    input wire logic LATCHED_BUS_SELECT,
    input wire logic COMMAND_DELAY_INPUT,
    // Control outputs
    output logic ADDR_LATCH_STROBE,
    output logic CASCADE_ADDRESS_ENABLE,
    output logic TRANSCEIVER_ENABLE,
    output logic TRANSFER_DIRECTION,
    // Command strobes, three-state
    output var cbcc_cmd_t CMD_STROBE_N,
    output logic CMD_STROBE_OE
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STATUS,
        ST_COMMAND
    } cbcc_bus_state_t;

    function automatic cbcc_cycle_t decode_cycle(input cbcc_status_t s);
        case ({s.mem_io_select, s.status1_n, s.status0_n})
            CODE_INT_ACK: decode_cycle = CYC_INT_ACK;
            CODE_IO_READ: decode_cycle = CYC_IO_READ;
            CODE_IO_WRITE: decode_cycle = CYC_IO_WRITE;
            CODE_HALT: decode_cycle = CYC_HALT;
            CODE_MEM_READ: decode_cycle = CYC_MEM_READ;
            CODE_MEM_WRITE: decode_cycle = CYC_MEM_WRITE;
            default: decode_cycle = CYC_NONE;
        endcase
    endfunction : decode_cycle

    function automatic cbcc_family_t family_of(input cbcc_cycle_t c);
        case (c)
            CYC_INT_ACK, CYC_IO_READ, CYC_MEM_READ: family_of = FAM_READ;
            CYC_IO_WRITE, CYC_MEM_WRITE: family_of = FAM_WRITE;
            CYC_HALT: family_of = FAM_HALT;
            default: family_of = FAM_NONE;
        endcase
    endfunction : family_of

    // One strobe per cycle type; everything else stays high
    function automatic cbcc_cmd_t strobe_for(input cbcc_cycle_t c, input logic active);
        cbcc_cmd_t v;
        v = CMD_ALL_INACTIVE;
        if (active) begin
            case (c)
                CYC_INT_ACK: v.int_ack_strobe_n = 1'b0;
                CYC_IO_READ: v.io_read_strobe_n = 1'b0;
                CYC_IO_WRITE: v.io_write_strobe_n = 1'b0;
                CYC_MEM_READ: v.mem_read_strobe_n = 1'b0;
                CYC_MEM_WRITE: v.mem_write_strobe_n = 1'b0;
                default: v = CMD_ALL_INACTIVE;
            endcase
        end
        strobe_for = v;
    endfunction : strobe_for

    cbcc_bus_state_t state_q, state_d;
    logic phase_q, phase_d;
    cbcc_cycle_t cyc_q, cyc_d;
    logic sel_q, sel_d;
    logic [1:0] idx_q, idx_d;
    logic go_q, go_d;
    logic ale_q, ale_d;
    logic mce_q, mce_d;
    logic den_q, den_d;
    logic dir_q, dir_d, read_dir_q, read_dir_d;
    logic oe_q, oe_d;
    cbcc_cmd_t cmd_n_q, cmd_n_d;
    logic grant_s;
    logic status_start;
    logic start_now;
    logic entering_tc;
    logic in_tc_next;
    logic sel_now;
    logic en_ok;
    logic [1:0] delay_need;
    cbcc_cycle_t dec_now;
    cbcc_family_t fam_q;

    // Async enable/grant is synchronised before use
    cbcc_sync u_grant_sync (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .async_in(COMMAND_ENABLE_OR_GRANT),
        .sync_out(grant_s)
    );

    assign dec_now = decode_cycle(BUS_STATUS);
    assign fam_q = family_of(cyc_q);
    assign status_start = !BUS_STATUS.status1_n || !BUS_STATUS.status0_n;
    assign start_now = (state_q == ST_IDLE) && status_start;
    assign entering_tc = (state_q == ST_STATUS);
    // Shared pin: grant is active low, enable is active high
    assign en_ok = SHARED_BUS_TIMING_STRAP ? !grant_s : grant_s;
    assign sel_now = entering_tc ? LATCHED_BUS_SELECT : sel_q;

    // Bus state sequencing, two clocks per state
    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        case (state_q)
            ST_IDLE: begin
                // Status seen low marks the end of phase 0 of the status state
                if (status_start) begin
                    state_d = ST_STATUS;
                    phase_d = 1'b1;
                end else begin
                    phase_d = 1'b0;
                end
            end
            ST_STATUS: begin
                state_d = ST_COMMAND;
                phase_d = 1'b0;
            end
            ST_COMMAND: begin
                if (!phase_q) begin
                    phase_d = 1'b1;
                end else if (!sel_q || fam_q != FAM_READ && fam_q != FAM_WRITE || !READY_N) begin
                    // Halt and unselected cycles do not wait on ready
                    state_d = ST_IDLE;
                    phase_d = 1'b0;
                end else begin
                    phase_d = 1'b0; // Wait state
                end
            end
            default: begin
                state_d = ST_IDLE;
                phase_d = 1'b0;
            end
        endcase
    end

    assign in_tc_next = (state_d == ST_COMMAND);

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            phase_q <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
        end
    end

    // Cycle type and bus select capture
    always_comb begin
        cyc_d = cyc_q;
        sel_d = sel_q;
        if (start_now) begin
            cyc_d = dec_now;
        end else if (state_d == ST_IDLE) begin
            cyc_d = CYC_NONE;
        end
        if (entering_tc) begin
            sel_d = LATCHED_BUS_SELECT;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cyc_q <= CYC_NONE;
            sel_q <= 1'b0;
        end else begin
            cyc_q <= cyc_d;
            sel_q <= sel_d;
        end
    end

    // Index of the current command-state clock, saturating
    always_comb begin
        if (entering_tc) begin
            idx_d = 2'h0;
        end else if (state_q == ST_COMMAND && idx_q != CMD_INDEX_MAX) begin
            idx_d = idx_q + 2'h1;
        end else begin
            idx_d = idx_q;
        end
    end

    // Shared-bus timing holds strobes back by one (read) or two (write) clocks
    always_comb begin
        if (fam_q == FAM_WRITE) begin
            delay_need = SHARED_BUS_TIMING_STRAP ? WRITE_DELAY_SHARED : WRITE_DELAY_FAST;
        end else begin
            delay_need = SHARED_BUS_TIMING_STRAP ? READ_DELAY_SHARED : READ_DELAY_FAST;
        end
    end

    // Command request: start needs delay input low, end follows ready
    always_comb begin
        go_d = 1'b0;
        if (in_tc_next && (fam_q == FAM_READ || fam_q == FAM_WRITE) && sel_now) begin
            if (go_q) begin
                go_d = 1'b1;
            end else if (!COMMAND_DELAY_INPUT && idx_d >= delay_need) begin
                go_d = 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            idx_q <= 2'h0;
            go_q <= 1'b0;
        end else begin
            idx_q <= idx_d;
            go_q <= go_d;
        end
    end

    // Strobes and their three-state enable
    always_comb begin
        cmd_n_d = strobe_for(cyc_q, go_d && en_ok);
        oe_d = !(SHARED_BUS_TIMING_STRAP && grant_s);
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_n_q <= CMD_ALL_INACTIVE;
            oe_q <= OE_RESET_VALUE;
        end else begin
            cmd_n_q <= cmd_n_d;
            oe_q <= oe_d;
        end
    end

    // Address latch and cascade enable ignore every control input
    always_comb begin
        ale_d = start_now && family_of(dec_now) != FAM_HALT;
        // Cascade enable outlasts the latch strobe by one clock
        mce_d = (start_now && dec_now == CYC_INT_ACK) || (entering_tc && cyc_q == CYC_INT_ACK);
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ale_q <= 1'b0;
            mce_q <= 1'b0;
        end else begin
            ale_q <= ale_d;
            mce_q <= mce_d;
        end
    end

    // Transceiver enable; fast writes open it before select is known
    always_comb begin
        den_d = 1'b0;
        if (start_now && family_of(dec_now) == FAM_WRITE && !SHARED_BUS_TIMING_STRAP) begin
            den_d = en_ok;
        end else if (in_tc_next && sel_now) begin
            if (fam_q == FAM_WRITE) begin
                den_d = en_ok;
            end else if (fam_q == FAM_READ && !entering_tc) begin
                den_d = en_ok;
            end
        end
    end

    // Direction follows cycle type and bus select, and moves only with enable off
    always_comb begin
        read_dir_d = fam_q == FAM_READ && in_tc_next && sel_now;
        dir_d = dir_q;
        if (!den_q && !den_d) begin
            dir_d = !(read_dir_d || read_dir_q);
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            den_q <= 1'b0;
            dir_q <= DIR_RESET_VALUE;
            read_dir_q <= 1'b0;
        end else begin
            den_q <= den_d;
            dir_q <= dir_d;
            read_dir_q <= read_dir_d;
        end
    end

    assign ADDR_LATCH_STROBE = ale_q;
    assign CASCADE_ADDRESS_ENABLE = mce_q;
    assign TRANSCEIVER_ENABLE = den_q;
    assign TRANSFER_DIRECTION = dir_q;
    assign CMD_STROBE_N = cmd_n_q;
    assign CMD_STROBE_OE = oe_q;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    chk_start_on_status: assert property (
        (state_q == ST_IDLE && status_start) |=> (state_q == ST_STATUS))
        else $error("status low did not start a bus cycle");

    chk_state_two_clocks: assert property (
        (state_q == ST_STATUS) |=> (state_q == ST_COMMAND && !phase_q) ##1
        (state_q == ST_COMMAND && phase_q))
        else $error("bus state did not last two clocks");

    chk_halt_quiet: assert property (
        (cyc_q == CYC_HALT) |-> (!ADDR_LATCH_STROBE && !TRANSCEIVER_ENABLE &&
        CMD_STROBE_N == CMD_ALL_INACTIVE && TRANSFER_DIRECTION))
        else $error("halt cycle drove an output");

    chk_cascade_ack_only: assert property (
        $rose(CASCADE_ADDRESS_ENABLE) |-> ADDR_LATCH_STROBE && cyc_q == CYC_INT_ACK
        ##1 (CASCADE_ADDRESS_ENABLE && !ADDR_LATCH_STROBE) ##1 !CASCADE_ADDRESS_ENABLE)
        else $error("cascade enable timing wrong");

    chk_latch_one_clock: assert property (
        (state_q == ST_IDLE && status_start && dec_now != CYC_HALT) |=>
        ADDR_LATCH_STROBE ##1 !ADDR_LATCH_STROBE)
        else $error("latch strobe not one clock in status state");

    chk_grant_tristate: assert property (
        (SHARED_BUS_TIMING_STRAP && grant_s) |=> (!CMD_STROBE_OE && !TRANSCEIVER_ENABLE))
        else $error("strobes not released while grant high");

    chk_fast_driven: assert property (
        (!SHARED_BUS_TIMING_STRAP && !grant_s) |=>
        (CMD_STROBE_OE && CMD_STROBE_N == CMD_ALL_INACTIVE && !TRANSCEIVER_ENABLE))
        else $error("fast mode enable low not honoured");

    chk_shared_write_den: assert property (
        (SHARED_BUS_TIMING_STRAP && TRANSCEIVER_ENABLE && fam_q == FAM_WRITE) |->
        (state_q == ST_COMMAND))
        else $error("shared write enable not delayed");

    chk_dir_no_contention: assert property (
        $changed(TRANSFER_DIRECTION) |-> (!TRANSCEIVER_ENABLE && !$past(TRANSCEIVER_ENABLE)))
        else $error("direction changed with transceiver enabled");

    chk_dir_idle_high: assert property (
        (state_q == ST_IDLE && $past(state_q) == ST_IDLE && !TRANSCEIVER_ENABLE &&
        !$past(TRANSCEIVER_ENABLE)) |-> TRANSFER_DIRECTION)
        else $error("direction low with no bus cycle");

    chk_shared_read_late: assert property (
        (SHARED_BUS_TIMING_STRAP && state_q == ST_COMMAND && idx_q == 2'h0) |->
        (CMD_STROBE_N == CMD_ALL_INACTIVE))
        else $error("shared-mode strobe started too early");

    chk_ready_release: assert property (
        (state_q == ST_COMMAND && phase_q && !READY_N) |=>
        (CMD_STROBE_N == CMD_ALL_INACTIVE && state_q == ST_IDLE))
        else $error("strobe not released after ready");

    cov_read_cycle: cover property (
        (state_q == ST_COMMAND && fam_q == FAM_READ && CMD_STROBE_N != CMD_ALL_INACTIVE));
    cov_write_wait: cover property (
        (state_q == ST_COMMAND && phase_q && fam_q == FAM_WRITE && READY_N) ##1
        (state_q == ST_COMMAND));
    cov_halt_cycle: cover property ((state_q == ST_STATUS && cyc_q == CYC_HALT));
    cov_int_ack: cover property ($rose(CASCADE_ADDRESS_ENABLE));

endmodule : cbcc_top
`default_nettype wire

/* cbcc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cbcc_cpu_model
    import cbcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus master side
    output var cbcc_status_t status,
    output var logic ready_n
);
    logic idle_mio = 1'b0;

    initial begin
        status = 3'h3;
        ready_n = 1'b0;
    end

    // Ready source pulls ready low while reset is applied
    always @(negedge rst_n) begin
        ready_n <= 1'b0;
    end

    // Every cycle spans an even clock count, so status always opens in phase 1
    task automatic run(input logic [2:0] code, input int waits, input bit no_ready);
        int i;
        @(posedge clk);
        status <= code;
        @(posedge clk);
        @(posedge clk);
        // Alternate idle encoding so both idle codes are exercised
        idle_mio = ~idle_mio;
        status <= {idle_mio, 2'h3};
        for (i = 0; i < 2 * waits + 2; i++) begin
            ready_n <= no_ready || (i < 2 * waits);
            @(posedge clk);
        end
        // Pulled-up ready line floats high once released
        ready_n <= 1'b1;
        @(posedge clk);
    endtask : run
endmodule : cbcc_cpu_model
`default_nettype wire

/* tb_cpu_bus_command_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_bus_command_controller;
    import cbcc_pkg::*;

    typedef struct {
        cbcc_cmd_t cmd;
        logic dir;
        logic [2:0] cascade_address_enable;
        int act;
        int transceiver_enable;
        int rel;
    } cbcc_exp_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b0;
    logic ceg = 1'b1;
    logic sel = 1'b1;
    logic dly = 1'b0;
    cbcc_status_t status;
    logic ready_n;
    logic ale, cascade_address_enable, transceiver_enable, dir, oe;
    cbcc_cmd_t cmd;
    cbcc_exp_t exp_q[$];
    cbcc_exp_t got;
    int err_count = 0;
    int comparisons = 0;
    int seed = 45;
    int t = 0;
    bit armed = 1'b0;
    logic dir_prev = 1'b1;
    logic den_prev = 1'b0;
    int n_ale = 0, n_mce = 0, n_cmd = 0, n_den = 0, n_dirlow = 0;
    logic [2:0] code_of [5] = '{CODE_INT_ACK, CODE_IO_READ, CODE_IO_WRITE,
                                CODE_MEM_READ, CODE_MEM_WRITE};

    initial begin
        forever #2.5 clk = ~clk;
    end

    cbcc_top dut (
        .REF_CLK(clk), .RST_N(rst_n), .BUS_STATUS(status), .READY_N(ready_n),
        .SHARED_BUS_TIMING_STRAP(strap), .COMMAND_ENABLE_OR_GRANT(ceg),
        .LATCHED_BUS_SELECT(sel), .COMMAND_DELAY_INPUT(dly),
        .ADDR_LATCH_STROBE(ale), .CASCADE_ADDRESS_ENABLE(cascade_address_enable),
        .TRANSCEIVER_ENABLE(transceiver_enable), .TRANSFER_DIRECTION(dir),
        .CMD_STROBE_N(cmd), .CMD_STROBE_OE(oe)
    );

    cbcc_cpu_model cpu (.clk(clk), .rst_n(rst_n), .status(status), .ready_n(ready_n));

    task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
        comparisons++;
        if (got_v !== exp_v) begin
            err_count++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got_v, exp_v);
        end
    endtask : check

    task automatic finish_test;
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    task automatic compare;
        cbcc_exp_t e;
        if (exp_q.size() == 0) begin
            check(32'h1, 32'h0);
            return;
        end
        e = exp_q.pop_front();
        check(32'(got.cmd), 32'(e.cmd));
        check(32'(got.dir), 32'(e.dir));
        check(32'(got.cascade_address_enable), 32'(e.cascade_address_enable));
        check(got.act, e.act);
        check(got.transceiver_enable, e.transceiver_enable);
        check(got.rel, e.rel);
    endtask : compare

    // Offsets counted in clocks from the address latch pulse
    always @(posedge clk) begin
        if (rst_n !== 1'b1) begin
            armed = 1'b0;
        end else begin
            n_ale += (ale === 1'b1);
            n_mce += (cascade_address_enable === 1'b1);
            n_den += (transceiver_enable === 1'b1);
            n_dirlow += (dir !== 1'b1);
            n_cmd += (oe === 1'b1 && cmd !== CMD_ALL_INACTIVE);
            if (dir !== dir_prev) begin
                check(32'(transceiver_enable | den_prev), 32'h0);
            end
            dir_prev = dir;
            den_prev = transceiver_enable;
            t = (ale === 1'b1) ? 0 : t + 1;
            if (ale === 1'b1) begin
                armed = 1'b1;
                got.act = -1;
                got.transceiver_enable = -1;
                got.cascade_address_enable = 3'h0;
            end
            if (armed && t < 3) got.cascade_address_enable[2 - t] = cascade_address_enable;
            if (armed && transceiver_enable === 1'b1 && got.transceiver_enable < 0) got.transceiver_enable = t;
            if (armed && got.act < 0 && oe === 1'b1 && cmd !== CMD_ALL_INACTIVE) begin
                got.act = t;
                got.cmd = cmd;
                got.dir = dir;
            end else if (armed && got.act >= 0 && cmd === CMD_ALL_INACTIVE) begin
                got.rel = t;
                armed = 1'b0;
                compare();
            end
        end
    end

    task automatic cyc(input int k, input int waits, input int hold);
        cbcc_exp_t e;
        bit wr;
        wr = (k == 2 || k == 4);
        e.cmd = CMD_ALL_INACTIVE ^ cbcc_cmd_t'(5'h10 >> k);
        e.dir = wr;
        e.cascade_address_enable = (k == 0) ? 3'h6 : 3'h0;
        e.act = 1 + hold + (strap ? (wr ? 2 : 1) : 0);
        e.transceiver_enable = wr ? (strap ? 1 : 0) : 2;
        e.rel = 3 + 2 * waits;
        exp_q.push_back(e);
        fork
            cpu.run(code_of[k], waits, 1'b0);
            if (hold > 0) begin
                repeat (2) @(posedge clk);
                dly <= 1'b1;
                repeat (hold) @(posedge clk);
                dly <= 1'b0;
            end
        join
    endtask : cyc

    // Cycles that must leave strobes and transceiver enable inactive
    task automatic quiet(input logic [2:0] code, input int waits, input bit no_ready,
                         input int e_ale, input int e_mce, input int e_dirlow);
        int s[5];
        #1;
        s = '{n_ale, n_mce, n_cmd, n_den, n_dirlow};
        cpu.run(code, waits, no_ready);
        #1;
        check(n_ale - s[0], e_ale);
        check(n_mce - s[1], e_mce);
        check(n_cmd - s[2], 0);
        check(n_den - s[3], 0);
        check(n_dirlow - s[4], e_dirlow);
        @(posedge clk);
    endtask : quiet

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end

    initial begin
        int k;
        int w;
        repeat (3) @(posedge clk);
        check({ale, cascade_address_enable, transceiver_enable, dir, oe, cmd}, 32'h07F);
        rst_n <= 1'b1;
        for (k = 0; k < 5; k++) begin
            cyc(k, 0, 0);
        end
        cyc(3, 1, 2);
        for (int i = 0; i < 10; i++) begin
            k = $unsigned($random(seed)) % 5;
            w = $unsigned($random(seed)) % 3;
            cyc(k, w, 0);
        end
        quiet(CODE_HALT, 0, 1'b1, 0, 0, 0);
        sel <= 1'b0;
        quiet(CODE_INT_ACK, 1, 1'b0, 1, 2, 0);
        sel <= 1'b1;
        ceg <= 1'b0;
        repeat (4) @(posedge clk);
        quiet(CODE_MEM_READ, 0, 1'b0, 1, 0, 3);
        ceg <= 1'b1;
        repeat (4) @(posedge clk);
        // Strap is static, so switch timing mode across a reset
        rst_n <= 1'b0;
        strap <= 1'b1;
        ceg <= 1'b0;
        repeat (3) @(posedge clk);
        check({ale, cascade_address_enable, transceiver_enable, dir, oe, cmd}, 32'h07F);
        rst_n <= 1'b1;
        for (k = 0; k < 5; k++) begin
            cyc(k, 1 + k % 2, 0);
        end
        ceg <= 1'b1;
        repeat (4) @(posedge clk);
        check(32'(oe), 32'h0);
        quiet(CODE_MEM_WRITE, 1, 1'b0, 1, 0, 0);
        check(32'(oe), 32'h0);
        ceg <= 1'b0;
        repeat (4) @(posedge clk);
        check({oe, cmd}, 32'h3F);
        cyc(2, 2, 0);
        repeat (2) @(posedge clk);
        check(exp_q.size(), 0);
        finish_test();
    end
endmodule : tb_cpu_bus_command_controller
`default_nettype wire
